// File: dog_timeout_counter.sv
/*
 * Time-out counter clocked by one-cycle ticks of the watchdog oscillator.
 * Assumes tick_en_i is already synchronised to core_clk_i.
 */
`default_nettype none

`include "wdt_defines.svh"

module dog_timeout_counter
    import wdt_pkg::*;
#(
    parameter int CNT_W = 21
) (
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       srst_i,
    // Control
    input  wire logic       tick_en_i,
    input  wire logic       run_i,
    input  wire logic       restart_i,
    input  wire logic [3:0] timeout_select_i,
    // Result
    output logic            timeout_o
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             timeout_q;
    logic             timeout_d;
    logic [3:0]       sel_eff;
    logic [CNT_W-1:0] limit;

    // Length of the time-out from the select code
    always_comb begin
        sel_eff = (timeout_select_i > `WDT_SEL_MAX) ? `WDT_SEL_MAX : timeout_select_i;
        limit   = CNT_W'(`WDT_BASE_TICKS << sel_eff);
    end

    // Count ticks only while running; a restart or stop clears the count
    always_comb begin
        cnt_d     = cnt_q;
        timeout_d = 1'b0;
        if (!run_i || restart_i) begin
            cnt_d = '0;
        end else if (tick_en_i) begin
            if (cnt_q >= limit - CNT_W'(1)) begin
                cnt_d     = '0;
                timeout_d = 1'b1;
            end else begin
                cnt_d = cnt_q + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cnt_q     <= '0;
            timeout_q <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            timeout_q <= timeout_d;
        end
    end

    assign timeout_o = timeout_q;

endmodule : dog_timeout_counter

`default_nettype wire

// File: tb.sv
/*
 * Self-checking bench for the watchdog time-out block.
 * Assumes a free-running watchdog oscillator at a quarter of the core rate.
 */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TO = 2048 * 4; // Core cycles in the shortest time-out

    logic        clk = 1'b0, srst = 1'b1, cold = 1'b1, we = 1'b0, re = 1'b0;
    logic        osc = 1'b0, fuse = 1'b0, restart = 1'b0, gie = 1'b1, ack = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic        irq, sysrst;
    logic [4:0]  vnum;
    logic [15:0] vaddr, raddr;
    int          err_total = 0;
    int          tests_run = 0;

    // Core clock and watchdog oscillator
    always #25 clk = ~clk;
    always #100 osc = ~osc;

    watchdog_timeout_and_vectoring i_watchdog_timeout_and_vectoring (
        .core_clk_i(clk), .srst_i(srst), .cold_start_i(cold), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
        .dog_osc_i(osc), .always_on_fuse_i(fuse), .dog_restart_i(restart),
        .global_irq_en_i(gie), .irq_ack_i(ack), .irq_req_o(irq),
        .irq_vector_num_o(vnum), .irq_vector_addr_o(vaddr), .sys_reset_o(sysrst),
        .reset_vector_addr_o(raddr));

    task automatic close_out;
        if (err_total == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chkb(input logic got);
        chk8({7'h00, got}, 8'h01);
    endtask : chkb

    task automatic do_reset(input logic c);
        srst <= 1'b1;
        cold <= c;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        cold <= 1'b0;
        @(posedge clk);
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 chk8(rdata, exp);
    endtask : rd

    // Bounded wait for an irq request or a reset pulse
    task automatic wait_ev(input bit use_irq, input int lo, input int hi);
        int n;
        n = 0;
        while (n <= hi && (use_irq ? irq : sysrst) !== 1'b1) begin
            @(posedge clk);
            #1 n++;
        end
        chkb(n >= lo && n <= hi);
    endtask : wait_ev

    task automatic t_regs;
        rd(8'h60, 8'h00);
        rd(8'h54, 8'h00);
        wr(8'h33, 8'hff);
        rd(8'h33, 8'h00);
        wr(8'h60, 8'h18);
        wr(8'h60, 8'h21);
        rd(8'h60, 8'h21);
        wr(8'h60, 8'h39);
        repeat (3) @(posedge clk);
        wr(8'h60, 8'h00);
        rd(8'h60, 8'h29);
        wr(8'h60, 8'h39);
        repeat (2) @(posedge clk);
        wr(8'h60, 8'h00);
        rd(8'h60, 8'h00);
    endtask : t_regs

    task automatic t_stopped;
        int n;
        n = 0;
        repeat (TO + 64) begin
            @(posedge clk);
            #1 if (sysrst === 1'b1 || irq === 1'b1) n++;
        end
        chkb(n == 0);
    endtask : t_stopped

    task automatic t_irq;
        wr(8'h60, 8'h18);
        wr(8'h60, 8'h01);
        wr(8'h60, 8'h40);
        wait_ev(1'b1, 2 * TO - 8, 2 * TO + 16);
        @(posedge clk);
        gie <= 1'b0;
        @(posedge clk);
        #1 chkb(irq === 1'b0);
        @(posedge clk);
        gie <= 1'b1;
        rd(8'h60, 8'hc1);
        chkb(irq === 1'b1);
        wr(8'h60, 8'hc0);
        rd(8'h60, 8'h41);
        wr(8'h60, 8'h18);
        wr(8'h60, 8'h00);
    endtask : t_irq

    task automatic t_both;
        wr(8'h60, 8'h48);
        wait_ev(1'b1, TO - 8, TO + 16);
        @(posedge clk);
        ack <= 1'b1;
        restart <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        restart <= 1'b0;
        rd(8'h60, 8'h08);
        wait_ev(1'b0, TO - 16, TO + 16);
        @(posedge clk);
        do_reset(1'b0);
        rd(8'h60, 8'h08);
        rd(8'h54, 8'h08);
        chk8({3'h0, vnum}, 8'h06);
        chk8(vaddr[15:8], 8'h00);
        chk8(vaddr[7:0], 8'h0a);
        chk8(raddr[15:8] | raddr[7:0], 8'h00);
        wr(8'h60, 8'h18);
        wr(8'h60, 8'h00);
        rd(8'h60, 8'h08);
        wr(8'h54, 8'h00);
        wr(8'h60, 8'h18);
        wr(8'h60, 8'h00);
        rd(8'h60, 8'h00);
    endtask : t_both

    task automatic t_fuse;
        @(posedge clk);
        fuse <= 1'b1;
        wr(8'h60, 8'h40);
        repeat (4) @(posedge clk);
        rd(8'h60, 8'h08);
        @(posedge clk);
        fuse <= 1'b0;
        repeat (4) @(posedge clk);
        wr(8'h60, 8'h18);
        wr(8'h60, 8'h00);
        rd(8'h60, 8'h00);
    endtask : t_fuse

    // Main sequence
    initial begin
        do_reset(1'b1);
        t_regs();
        t_stopped();
        t_irq();
        t_both();
        t_fuse();
        close_out();
    end

    // Hang guard, about twice the planned run
    initial begin
        #(70000 * 50);
        err_total++;
        close_out();
    end
endmodule : tb

`default_nettype wire

// File: watchdog_timeout_and_vectoring.sv
/*
 * Watchdog control register, reset-cause flag, time-out action and vectoring.
 * Assumes the watchdog oscillator and the fuse arrive as asynchronous pins,
 * and that the core drives the register port and the interrupt ack on
 * core_clk_i.
 */
// Decided for this implementation: the register addresses and the address-and-strobe port.
`default_nettype none

`include "wdt_defines.svh"

module watchdog_timeout_and_vectoring
    import wdt_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1,
    parameter int CNT_W         = 21
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic        cold_start_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_we_i,
    input  wire logic        reg_re_i,
    output logic      [7:0]  reg_rdata_o,
    // Pins
    input  wire logic        dog_osc_i,
    input  wire logic        always_on_fuse_i,
    // Core interface
    input  wire logic        dog_restart_i,
    input  wire logic        global_irq_en_i,
    input  wire logic        irq_ack_i,
    output logic             irq_req_o,
    output logic      [4:0]  irq_vector_num_o,
    output logic      [15:0] irq_vector_addr_o,
    output logic             sys_reset_o,
    output logic      [15:0] reset_vector_addr_o
);

    // Synchronisers for the asynchronous pins
    logic [1:0] osc_sync_q;
    logic [1:0] fuse_sync_q;
    logic       osc_prev_q;
    logic       tick_en;
    logic       fuse;

    // Two flip-flops per pin; only the second stage feeds logic
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            osc_sync_q  <= 2'b00;
            fuse_sync_q <= 2'b00;
            osc_prev_q  <= 1'b0;
        end else begin
            osc_sync_q  <= {osc_sync_q[0], dog_osc_i};
            fuse_sync_q <= {fuse_sync_q[0], always_on_fuse_i};
            osc_prev_q  <= osc_sync_q[1];
        end
    end

    // Rising edge of the oscillator becomes a one-cycle tick
    assign tick_en = osc_sync_q[1] & ~osc_prev_q;
    assign fuse    = fuse_sync_q[1];

    // Control and status state
    logic       irq_flag_q,   irq_flag_d;
    logic       irq_en_q,     irq_en_d;
    logic       rst_en_q,     rst_en_d;
    logic [3:0] sel_q,        sel_d;
    logic       unlock_q,     unlock_d;
    logic [2:0] unlock_cnt_q, unlock_cnt_d;
    logic       dog_flag_q,   dog_flag_d;
    logic       rst_en_eff;
    logic       irq_en_eff;
    logic       running;
    logic       timeout;
    logic       fire_reset;
    logic       fire_irq;
    logic       wr_ctrl;
    logic       wr_cause;
    dog_mode_e  mode;

    // Register decode, writes only
    assign wr_ctrl  = reg_we_i && (reg_addr_i == `WDT_ADDR_CTRL);
    assign wr_cause = reg_we_i && (reg_addr_i == `WDT_ADDR_CAUSE);

    // Effective enables after the fuse and the latched flag
    always_comb begin
        rst_en_eff = rst_en_q | dog_flag_q | fuse;
        irq_en_eff = irq_en_q & ~fuse;
        running    = rst_en_eff | irq_en_eff;
        unique case ({rst_en_eff, irq_en_eff})
            2'b00:   mode = MODE_STOPPED;
            2'b01:   mode = MODE_IRQ;
            2'b11:   mode = MODE_IRQ_RST;
            2'b10:   mode = MODE_RST;
        endcase
    end

    // Action on a time-out
    always_comb begin
        fire_reset = 1'b0;
        fire_irq   = 1'b0;
        if (timeout) begin
            unique case (mode)
                MODE_STOPPED: begin
                    fire_reset = 1'b0;
                end
                MODE_IRQ: begin
                    fire_irq = 1'b1;
                end
                MODE_IRQ_RST: begin
                    fire_irq   = ~irq_flag_q;
                    fire_reset = irq_flag_q;
                end
                MODE_RST: begin
                    fire_reset = 1'b1;
                end
            endcase
        end
    end

    // Register updates; hardware sets beat software clears
    always_comb begin
        irq_flag_d   = irq_flag_q;
        irq_en_d     = irq_en_q;
        rst_en_d     = rst_en_q;
        sel_d        = sel_q;
        unlock_d     = unlock_q;
        unlock_cnt_d = unlock_cnt_q;
        dog_flag_d   = dog_flag_q;

        // Window counts core cycles, not oscillator ticks
        // window closes after four cycles
        if (unlock_q) begin
            if (unlock_cnt_q == `WDT_UNLOCK_CYCLES - 3'h1) begin
                unlock_d     = 1'b0;
                unlock_cnt_d = 3'h0;
            end else begin
                unlock_cnt_d = unlock_cnt_q + 3'h1;
            end
        end

        if (wr_ctrl) begin
            // Irq enable needs no unlock
            irq_en_d = reg_wdata_i[`WDT_BIT_IRQ_EN];
            if (reg_wdata_i[`WDT_BIT_IRQ_FLAG]) begin
                irq_flag_d = 1'b0;
            end
            if (reg_wdata_i[`WDT_BIT_UNLOCK] && reg_wdata_i[`WDT_BIT_RST_EN]) begin
                unlock_d     = 1'b1;
                unlock_cnt_d = 3'h0;
                rst_en_d     = 1'b1;
            end else if (unlock_q) begin
                rst_en_d = reg_wdata_i[`WDT_BIT_RST_EN];
                sel_d    = {reg_wdata_i[`WDT_BIT_SEL_HI],
                            reg_wdata_i[`WDT_SEL_LO_MSB:0]};
                unlock_d     = 1'b0;
                unlock_cnt_d = 3'h0;
            end else if (reg_wdata_i[`WDT_BIT_RST_EN]) begin
                // Setting the enable needs no unlock
                rst_en_d = 1'b1;
            end
        end

        // Software clears the latched flag by writing zero
        if (wr_cause && !reg_wdata_i[`WDT_CAUSE_FLAG_BIT]) begin
            dog_flag_d = 1'b0;
        end

        if (irq_ack_i) begin
            irq_flag_d = 1'b0;
            // ack falls back to reset mode
            if (rst_en_eff) begin
                irq_en_d = 1'b0;
            end
        end

        // Sets come last, so a clear in the same cycle loses
        // time-out sets flag
        if (fire_irq) begin
            irq_flag_d = 1'b1;
        end
        if (fire_reset) begin
            dog_flag_d = 1'b1;
        end
        if (dog_flag_d) begin
            rst_en_d = 1'b1;
        end
        if (fuse) begin
            irq_en_d = 1'b0;
        end
    end

    // Control state registers
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            irq_flag_q   <= 1'b0;
            irq_en_q     <= 1'b0;
            sel_q        <= 4'h0;
            unlock_q     <= 1'b0;
            unlock_cnt_q <= 3'h0;
            // Flag survives a warm reset so software can see the cause
            dog_flag_q   <= cold_start_i ? 1'b0 : dog_flag_q;
            rst_en_q     <= cold_start_i ? 1'b0 : dog_flag_q;
        end else begin
            irq_flag_q   <= irq_flag_d;
            irq_en_q     <= irq_en_d;
            rst_en_q     <= rst_en_d;
            sel_q        <= sel_d;
            unlock_q     <= unlock_d;
            unlock_cnt_q <= unlock_cnt_d;
            dog_flag_q   <= dog_flag_d;
        end
    end

    // Shortening the select mid-count can time out on the next tick,
    // so software should restart the count before a change
    // counter runs only when enabled
    dog_timeout_counter #(
        .CNT_W (CNT_W)
    ) u_counter (
        .core_clk_i       (core_clk_i),
        .srst_i           (srst_i),
        .tick_en_i        (tick_en),
        .run_i            (running),
        .restart_i        (dog_restart_i),
        .timeout_select_i (sel_q),
        .timeout_o        (timeout)
    );

    // Read data and core-facing outputs
    logic [7:0]  rdata_q,    rdata_d;
    logic        irq_req_q,  irq_req_d;
    logic        sys_rst_q,  sys_rst_d;
    logic [15:0] irq_addr_q, irq_addr_d;
    logic [4:0]  irq_num_q,  irq_num_d;
    logic [15:0] rst_addr_q, rst_addr_d;

    // Read mux and next values of the core-facing outputs
    always_comb begin
        rdata_d = 8'h00;
        if (reg_re_i) begin
            if (reg_addr_i == `WDT_ADDR_CTRL) begin
                rdata_d[`WDT_BIT_IRQ_FLAG]   = irq_flag_q;
                rdata_d[`WDT_BIT_IRQ_EN]     = irq_en_eff;
                rdata_d[`WDT_BIT_SEL_HI]     = sel_q[3];
                rdata_d[`WDT_BIT_UNLOCK]     = unlock_q;
                rdata_d[`WDT_BIT_RST_EN]     = rst_en_eff;
                rdata_d[`WDT_SEL_LO_MSB:0]   = sel_q[2:0];
            end else if (reg_addr_i == `WDT_ADDR_CAUSE) begin
                rdata_d[`WDT_CAUSE_FLAG_BIT] = dog_flag_q;
            end
        end
        // Request drops on ack so the core does not take it twice
        irq_req_d  = irq_flag_d & irq_en_eff & global_irq_en_i & ~irq_ack_i;
        // dog reset goes through reset vector
        sys_rst_d  = fire_reset;
        rst_addr_d = `WDT_RESET_VEC_ADDR;
        irq_num_d  = `WDT_VEC_NUM;
        irq_addr_d = LARGE_VARIANT ? `WDT_VEC_ADDR_LARGE : `WDT_VEC_ADDR_SMALL;
    end

    // Output registers, so every port comes from a flip-flop
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rdata_q    <= 8'h00;
            irq_req_q  <= 1'b0;
            sys_rst_q  <= 1'b0;
            rst_addr_q <= `WDT_RESET_VEC_ADDR;
            irq_num_q  <= `WDT_VEC_NUM;
            irq_addr_q <= LARGE_VARIANT ? `WDT_VEC_ADDR_LARGE : `WDT_VEC_ADDR_SMALL;
        end else begin
            rdata_q    <= rdata_d;
            irq_req_q  <= irq_req_d;
            sys_rst_q  <= sys_rst_d;
            rst_addr_q <= rst_addr_d;
            irq_num_q  <= irq_num_d;
            irq_addr_q <= irq_addr_d;
        end
    end

    // Ports straight from the output registers
    assign reg_rdata_o         = rdata_q;
    assign irq_req_o           = irq_req_q;
    assign irq_vector_num_o    = irq_num_q;
    assign irq_vector_addr_o   = irq_addr_q;
    assign sys_reset_o         = sys_rst_q;
    assign reset_vector_addr_o = rst_addr_q;

endmodule : watchdog_timeout_and_vectoring

`default_nettype wire

// File: wdt_chk_asserts.sv
/*
 * Port checker for the watchdog time-out block.
 * Assumes it is bound onto watchdog_timeout_and_vectoring.
 */
`default_nettype none

module wdt_chk #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    // Register port and pins
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_re_i,
    input  wire logic [7:0]  reg_rdata_o,
    input  wire logic        always_on_fuse_i,
    // Core side
    input  wire logic        global_irq_en_i,
    input  wire logic        irq_ack_i,
    input  wire logic        irq_req_o,
    input  wire logic [4:0]  irq_vector_num_o,
    input  wire logic [15:0] irq_vector_addr_o,
    input  wire logic        sys_reset_o,
    input  wire logic [15:0] reset_vector_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    // Read data only in the slot after a read
    property p_rd_idle; !reg_re_i |=> reg_rdata_o == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");

    // Unmapped reads give zero
    property p_unmapped;
        reg_re_i && reg_addr_i != 8'h60 && reg_addr_i != 8'h54 |=> reg_rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    // Cause register holds only the latched flag
    property p_cause_bits;
        reg_re_i && reg_addr_i == 8'h54 |=> (reg_rdata_o & 8'hf7) == 8'h00;
    endproperty
    a_cause_bits: assert property (p_cause_bits) else $error("cause spare bits set");

    property p_vec; irq_vector_num_o == 5'h06 &&
        irq_vector_addr_o == (LARGE_VARIANT ? 16'h000a : 16'h0005); endproperty
    a_vec: assert property (p_vec) else $error("wrong irq vector");

    property p_rst_vec; reset_vector_addr_o == 16'h0000; endproperty
    a_rst_vec: assert property (p_rst_vec) else $error("wrong reset vector");

    property p_rst_pulse; sys_reset_o |=> !sys_reset_o; endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");

    property p_irq_gate; irq_req_o |-> $past(global_irq_en_i); endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");

    property p_ack_clr; irq_ack_i |-> ##2 !irq_req_o; endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("irq kept after ack");

    property p_fuse_lock;
        always_on_fuse_i [*5] ##0 (reg_re_i && reg_addr_i == 8'h60)
            |=> reg_rdata_o[3] && !reg_rdata_o[6];
    endproperty
    a_fuse_lock: assert property (p_fuse_lock) else $error("fuse lock not shown");

    // Main scenarios reached
    c_rst: cover property (sys_reset_o);
    c_irq: cover property (irq_req_o);
    c_ack: cover property (irq_ack_i ##2 !irq_req_o);
endmodule : wdt_chk

bind watchdog_timeout_and_vectoring wdt_chk #(.LARGE_VARIANT(LARGE_VARIANT)) i_wdt_chk (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .always_on_fuse_i(always_on_fuse_i),
    .global_irq_en_i(global_irq_en_i), .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o),
    .irq_vector_num_o(irq_vector_num_o), .irq_vector_addr_o(irq_vector_addr_o),
    .sys_reset_o(sys_reset_o), .reset_vector_addr_o(reset_vector_addr_o));

`default_nettype wire

// File: wdt_defines.svh
/*
 * Constants of the watchdog time-out block: offsets, bit positions, counts.
 * Assumes it is included by bare name after the package and before modules.
 */
// Summary of operation
// - Latched dog reset flag forces reset enable.
// - Select is bit5 plus bits2:0, 2048..1048576 ticks.
// - Stopped watchdog does no time-out counting.
// - Dog reset restarts at reset vector 0x0000.
// - Time-out interrupt uses vector 6, 0x0005/0x000A.
// - Unlock write opens four-cycle change window.
// - Always-on fuse forces reset mode, irq off.
// - Both enables: interrupt first, then reset.
// - Irq flag set on time-out, cleared by ack/one.
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

`define WDT_ADDR_CTRL       8'h60
`define WDT_ADDR_CAUSE      8'h54
`define WDT_CAUSE_FLAG_BIT  3
`define WDT_BIT_IRQ_FLAG    7
`define WDT_BIT_IRQ_EN      6
`define WDT_BIT_SEL_HI      5
`define WDT_BIT_UNLOCK      4
`define WDT_BIT_RST_EN      3
`define WDT_SEL_LO_MSB      2
`define WDT_CTRL_RESET      8'h00
`define WDT_BASE_TICKS      21'h000800
`define WDT_SEL_MAX         4'h9
`define WDT_UNLOCK_CYCLES   3'h4
`define WDT_VEC_NUM         5'h06
`define WDT_VEC_ADDR_SMALL  16'h0005
`define WDT_VEC_ADDR_LARGE  16'h000a
`define WDT_RESET_VEC_ADDR  16'h0000

`endif

// File: wdt_pkg.sv
/*
 * Types shared by the watchdog time-out block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package wdt_pkg;

    // Action taken when a time-out arrives, Gray coded
    typedef enum logic [1:0] {
        MODE_STOPPED  = 2'b00,
        MODE_IRQ      = 2'b01,
        MODE_IRQ_RST  = 2'b11,
        MODE_RST      = 2'b10
    } dog_mode_e;

endpackage : wdt_pkg

`default_nettype wire
